//--- design/sim_pkg.sv
/*
 * Constants for the supply integrity monitor: register map, field
 * positions, reset values and reset delay counts.
 * Assumes a 20 MHz CPU clock and a 32-bit AXI4-Lite register bus.
 */
package sim_pkg;
  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] SIM_CTRL_STATUS_OFS = 8'h00;
  localparam logic [7:0] SIM_MON_STATUS_OFS  = 8'h04;

  // ****************************************************************
  // Control/status fields
  // ****************************************************************
  localparam int SIM_WDG_RF_BIT = 0;
  localparam int SIM_LVD_RF_BIT = 4;
  localparam int SIM_AUX_F_BIT  = 5;
  localparam int SIM_AUX_IE_BIT = 6;
  localparam logic [7:0] SIM_CTRL_RESET = 8'h00;

  // ****************************************************************
  // Monitor status fields
  // ****************************************************************
  localparam int SIM_MON_RST_BIT  = 0;
  localparam int SIM_MON_LVD_BIT  = 1;
  localparam int SIM_MON_AUX_BIT  = 2;
  localparam int SIM_MON_EN_BIT   = 3;
  localparam int SIM_MON_THR_LSB  = 4;
  localparam int SIM_MON_LONG_BIT = 6;

  // ****************************************************************
  // Reset delay in CPU cycles and answers
  // ****************************************************************
  localparam logic [12:0] SIM_SHORT_DELAY = 13'h0100;
  localparam logic [12:0] SIM_LONG_DELAY  = 13'h1000;
  localparam logic [1:0]  SIM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SIM_RESP_SLVERR = 2'h2;

  // Gray coded along hold -> delay -> run
  typedef enum logic [1:0] {
    SIM_HOLD  = 2'b01,
    SIM_DELAY = 2'b11,
    SIM_RUN   = 2'b10
  } sim_phase_t;
endpackage

//--- design/sim_supply_monitor.sv
/*
 * Supply integrity monitor: low-voltage reset with hysteresis, reset
 * delay, auxiliary detector flag with change interrupt, and reset
 * source flags, reached over AXI4-Lite.
 * Assumes comparators are asynchronous, option settings are stable
 * nonvolatile levels, and aresetn is the power-on reset of the block.
 */
// Our own choices: the register offsets and the AXI4-Lite register port.
// Operation
// - Hold static reset while supply below threshold; upper rising, lower falling.
// - Drive reset pin low during low-voltage reset.
// - Threshold low, medium or high chosen by nonvolatile option.
// - Detector optional by option; disabled means no low-voltage reset.
// - Bit 5 read-only flag follows auxiliary comparator in real time.
// - Auxiliary detector works only when low-voltage detector enabled.
// - With enable bit 6 set, each flag change latches interrupt.
// - Forward request only when enabled and global mask cleared.
// - Pending request clears on entry to its service routine.
// - No interrupt for crossing inside the 256 or 4096 cycle delay.
// - Slow rise, early enable: one interrupt at enable, one at crossing.
// - Enable after crossing gives exactly one interrupt.
// - Wait keeps working and wakes on interrupt; Halt does not wake.
// - Control/status register frozen during Halt.
// - Bit 4 set by low-voltage reset, cleared by writing zero.
// - Pin and watchdog resets leave bit 4 unchanged.
// - Bit 0 set by watchdog reset, cleared by zero write or LOW_VOLTAGE_DETECTOR reset.
// - Flags encode last reset: pin, watchdog or supply.
`timescale 1ns/1ps
`default_nettype none
module sim_supply_monitor
  import sim_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Nonvolatile option settings
  input  wire logic              opt_lvd_enable,
  input  wire logic [1:0]        opt_threshold,
  input  wire logic              opt_long_delay,
  // Comparators and threshold selection
  input  wire logic              lvd_below,
  input  wire logic              aux_below,
  output logic [1:0]             lvd_threshold_sel,
  output logic                   lvd_use_upper,
  output logic                   aux_use_upper,
  // Reset sources and reset pin
  input  wire logic              wdg_reset,
  output logic                   sys_reset_req,
  output logic                   reset_pin_o,
  output logic                   reset_pin_oe,
  // Processor side
  input  wire logic              global_irq_mask,
  input  wire logic              aux_irq_ack,
  input  wire logic              wait_mode,
  input  wire logic              halt_mode,
  output logic                   aux_irq,
  output logic                   wake_req
);
  import sim_pkg::*;

  initial begin
    if (ADDR_W < 3 || ADDR_W > 8) begin
      $error("ADDR_W must lie in 3..8");
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic              lvd_s1;
    logic              lvd_s2;
    logic              aux_s1;
    logic              aux_s2;
    logic              opt_done;
    logic              lvd_en;
    logic [1:0]        thr;
    logic              long_dly;
    sim_phase_t        phase;
    logic [12:0]       cnt;
    logic              flag;
    logic              seen;
    logic              irq_en;
    logic              pend;
    logic              lvd_rf;
    logic              wdg_rf;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [7:0]        wdata;
    logic              wstrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
  } sim_state_t;

  sim_state_t st_reg;
  sim_state_t st_next;

  logic [7:0] ctrl_view;
  logic [7:0] mon_view;
  logic [7:0] aw_ofs;
  logic [7:0] ar_ofs;

  always_comb begin
    ctrl_view = SIM_CTRL_RESET;
    ctrl_view[SIM_WDG_RF_BIT] = st_reg.wdg_rf;
    ctrl_view[SIM_LVD_RF_BIT] = st_reg.lvd_rf;
    ctrl_view[SIM_AUX_F_BIT]  = st_reg.flag;
    ctrl_view[SIM_AUX_IE_BIT] = st_reg.irq_en;
    mon_view = 8'h00;
    mon_view[SIM_MON_RST_BIT] = (st_reg.phase != SIM_RUN);
    mon_view[SIM_MON_LVD_BIT] = st_reg.lvd_s2;
    mon_view[SIM_MON_AUX_BIT] = st_reg.aux_s2;
    mon_view[SIM_MON_EN_BIT]  = st_reg.lvd_en;
    mon_view[SIM_MON_THR_LSB +: 2] = st_reg.thr;
    mon_view[SIM_MON_LONG_BIT] = st_reg.long_dly;
    aw_ofs = 8'(st_reg.awaddr) & 8'hfc;
    ar_ofs = 8'(s_axi_araddr) & 8'hfc;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic lvd_fault;
  logic aux_live;
  logic wr_fire;
  logic wr_ctrl;
  logic en_rise;

  always_comb begin
    st_next = st_reg;
    lvd_fault = 1'b0;
    aux_live = 1'b0;
    wr_fire = 1'b0;
    wr_ctrl = 1'b0;
    en_rise = 1'b0;

    // Second flop alone reads the first
    st_next.lvd_s1 = lvd_below;
    st_next.lvd_s2 = st_reg.lvd_s1;
    st_next.aux_s1 = aux_below;
    st_next.aux_s2 = st_reg.aux_s1;

    // Options are latched once, after reset release
    if (!st_reg.opt_done) begin
      st_next.opt_done = 1'b1;
      st_next.lvd_en = opt_lvd_enable;
      st_next.thr = opt_threshold;
      st_next.long_dly = opt_long_delay;
    end

    lvd_fault = st_reg.opt_done && st_reg.lvd_en
                && st_reg.lvd_s2;

    // Reset sequencing
    unique case (st_reg.phase)
      SIM_HOLD: begin
        if (st_reg.opt_done && !lvd_fault) begin
          st_next.phase = SIM_DELAY;
          st_next.cnt = st_reg.long_dly ? SIM_LONG_DELAY
                                        : SIM_SHORT_DELAY;
        end
      end
      SIM_DELAY: begin
        if (lvd_fault) begin
          st_next.phase = SIM_HOLD;
        end else if (st_reg.cnt == 13'h0001) begin
          st_next.phase = SIM_RUN;
          st_next.cnt = 13'h0000;
        end else begin
          st_next.cnt = st_reg.cnt - 13'h0001;
        end
      end
      SIM_RUN: begin
        if (lvd_fault) begin
          st_next.phase = SIM_HOLD;
        end
      end
    endcase

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata[7:0];
      st_next.wstrb0 = s_axi_wstrb[0];
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      wr_fire = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      if (aw_ofs == SIM_CTRL_STATUS_OFS
          || aw_ofs == SIM_MON_STATUS_OFS) begin
        st_next.bresp = SIM_RESP_OKAY;
      end else begin
        st_next.bresp = SIM_RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Writes in Halt are answered but do not land
    wr_ctrl = wr_fire && st_reg.wstrb0 && !halt_mode
              && aw_ofs == SIM_CTRL_STATUS_OFS;

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = SIM_RESP_OKAY;
      if (ar_ofs == SIM_CTRL_STATUS_OFS) begin
        st_next.rdata = ctrl_view;
      end else if (ar_ofs == SIM_MON_STATUS_OFS) begin
        st_next.rdata = mon_view;
      end else begin
        st_next.rdata = 8'h00;
        st_next.rresp = SIM_RESP_SLVERR;
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Control/status contents, frozen in Halt
    if (!halt_mode) begin
      if (wr_ctrl) begin
        st_next.irq_en = st_reg.wdata[SIM_AUX_IE_BIT];
        en_rise = st_reg.wdata[SIM_AUX_IE_BIT] && !st_reg.irq_en;
        // Only a zero clears; a one leaves the flag alone
        if (!st_reg.wdata[SIM_LVD_RF_BIT]) begin
          st_next.lvd_rf = 1'b0;
        end
        if (!st_reg.wdata[SIM_WDG_RF_BIT]) begin
          st_next.wdg_rf = 1'b0;
        end
      end
      // Hardware sets win over a clearing write
      // Watchdog leaves the low-voltage flag alone
      if (wdg_reset) begin
        st_next.wdg_rf = 1'b1;
      end
      if (lvd_fault) begin
        st_next.lvd_rf = 1'b1;
        st_next.wdg_rf = 1'b0;
      end

      aux_live = st_reg.opt_done && st_reg.lvd_en;
      st_next.flag = aux_live && st_reg.aux_s2;
      st_next.seen = st_reg.flag;
      if (!aux_live) begin
        st_next.pend = 1'b0;
      end else begin
        if (aux_irq_ack) begin
          st_next.pend = 1'b0;
        end
        // Crossings inside the reset delay are absorbed silently
        if (st_reg.phase == SIM_RUN
            && st_reg.flag != st_reg.seen) begin
          st_next.pend = 1'b1;
        end
        // Enabling while below the threshold reports that state
        if (en_rise && st_reg.flag) begin
          st_next.pend = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.phase <= SIM_HOLD;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = {24'h000000, st_reg.rdata};
  assign s_axi_rresp   = st_reg.rresp;

  assign lvd_threshold_sel = st_reg.thr;
  // Hysteresis: in reset wait for the upper level, else watch lower
  assign lvd_use_upper = (st_reg.phase != SIM_RUN);
  assign aux_use_upper = st_reg.flag;

  assign sys_reset_req = (st_reg.phase != SIM_RUN);
  // Open drain: only ever pulls low
  assign reset_pin_o  = 1'b0;
  assign reset_pin_oe = (st_reg.phase != SIM_RUN);

  // Request pending and enabled is what wakes from Wait
  assign aux_irq  = st_reg.pend && st_reg.irq_en
                    && !global_irq_mask;
  assign wake_req = st_reg.pend && st_reg.irq_en
                    && wait_mode && !halt_mode;

endmodule
`default_nettype wire

//--- testbench/sim_supply_monitor_chk.sv
/* Concurrent checks on the supply integrity monitor top ports.
   Assumes option inputs change only while aresetn is low. */
`timescale 1ns/1ps
`default_nettype none
module sim_supply_monitor_chk (
  // Clock, reset and options
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       opt_lvd_enable,
  input wire logic [1:0] opt_threshold,
  // Supply side
  input wire logic       lvd_below,
  input wire logic       aux_below,
  input wire logic [1:0] lvd_threshold_sel,
  input wire logic       lvd_use_upper,
  input wire logic       aux_use_upper,
  input wire logic       sys_reset_req,
  input wire logic       reset_pin_oe,
  // Processor side
  input wire logic       global_irq_mask,
  input wire logic       wait_mode,
  input wire logic       halt_mode,
  input wire logic       aux_irq,
  input wire logic       wake_req
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pin; reset_pin_oe == sys_reset_req && lvd_use_upper == sys_reset_req; endproperty
  a_pin: assert property (p_pin) else $error("reset pin mismatch");
  property p_hold; (opt_lvd_enable && lvd_below) [*4] |-> sys_reset_req; endproperty
  a_hold: assert property (p_hold) else $error("no reset when low");
  property p_delay; $fell(sys_reset_req) |-> $past(sys_reset_req, 256)
    && !(opt_lvd_enable && $past(lvd_below, 3)); endproperty
  a_delay: assert property (p_delay) else $error("delay short");
  property p_off; !opt_lvd_enable && !sys_reset_req |=> !sys_reset_req && !aux_use_upper; endproperty
  a_off: assert property (p_off) else $error("detector not off");
  property p_flag; (opt_lvd_enable && !halt_mode) [*4] |-> aux_use_upper == $past(aux_below, 3); endproperty
  a_flag: assert property (p_flag) else $error("flag lags");
  property p_irq; aux_irq |-> !global_irq_mask; endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  property p_wake; !global_irq_mask |-> wake_req == (aux_irq && wait_mode && !halt_mode); endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");
  property p_halt; halt_mode && $past(halt_mode) && $stable(global_irq_mask)
    |-> $stable(aux_use_upper) && $stable(aux_irq); endproperty
  a_halt: assert property (p_halt) else $error("halt not frozen");
  property p_thr; $rose(aresetn) |-> ##2 lvd_threshold_sel == opt_threshold; endproperty
  a_thr: assert property (p_thr) else $error("threshold mismatch");
  c_wake: cover property (wake_req);
  c_run: cover property ($fell(sys_reset_req));
  c_halt: cover property (halt_mode && aux_use_upper);
endmodule
bind sim_supply_monitor sim_supply_monitor_chk u_sim_supply_monitor_chk (.*);
`default_nettype wire

//--- testbench/sim_supply_monitor_tb.sv
/* Self-checking bench for the supply integrity monitor.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module sim_supply_monitor_tb;
  import sim_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, opt_lvd_enable, opt_long_delay;
  logic lvd_below, aux_below, wdg_reset, global_irq_mask, aux_irq_ack;
  logic wait_mode, halt_mode, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, lvd_use_upper, aux_use_upper;
  logic sys_reset_req, reset_pin_o, reset_pin_oe, aux_irq, wake_req;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  opt_threshold, s_axi_bresp, s_axi_rresp, lvd_threshold_sel, rsp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  int          failures, comparisons, seed, n;
  int          cyc = 0;
  localparam logic [3:0] CS = 4'h0;
  sim_supply_monitor u_sim_supply_monitor (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .opt_lvd_enable, .opt_threshold, .opt_long_delay, .lvd_below,
    .aux_below, .lvd_threshold_sel, .lvd_use_upper, .aux_use_upper,
    .wdg_reset, .sys_reset_req, .reset_pin_o, .reset_pin_oe,
    .global_irq_mask, .aux_irq_ack, .wait_mode, .halt_mode, .aux_irq,
    .wake_req
  );
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Longest path is the 4096 cycle delay plus a few hundred bus cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 12000) begin
      failures++;
      conclude();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  function automatic logic [31:0] cx(input logic ie, f, lrf, wrf);
    return {25'h0, ie, f, lrf, 3'h0, wrf};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] e);
    rd(CS);
    chk("ctrl", e, rdv);
  endtask
  task automatic ack();
    aux_irq_ack <= 1'b1;
    @(posedge aclk);
    aux_irq_ack <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rst(input logic en, lg);
    aresetn <= 1'b0;
    opt_lvd_enable <= en;
    opt_long_delay <= lg;
    opt_threshold <= 2'($random(seed));
    tick(16);
    aresetn <= 1'b1;
    tick(2);
  endtask
  task automatic run_wait(input int lo, hi);
    n = 0;
    while (sys_reset_req && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    chkb("delay", 1'b1, n > lo && n < hi);
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    seed = 73;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, wdg_reset, global_irq_mask} = '0;
    {aux_irq_ack, wait_mode, halt_mode, opt_long_delay} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {opt_threshold, s_axi_wdata} = '0;
    {opt_lvd_enable, lvd_below, aux_below} = 3'h7;
    s_axi_wstrb = 4'hf;
    rst(1'b1, 1'b0);
    tick(300);
    chkb("sys_reset_req", 1'b1, sys_reset_req);
    lvd_below <= 1'b0;
    tick(100);
    aux_below <= 1'b0;
    run_wait(155, 165);
    rc(cx(0, 0, 1, 0));
    wr(CS, 32'h50);
    tick(4);
    chkb("aux_irq", 1'b0, aux_irq);
    aux_below <= 1'b1;
    tick(6);
    chkb("aux_irq", 1'b1, aux_irq);
    ack();
    chkb("aux_irq", 1'b0, aux_irq);
    aux_below <= 1'b0;
    tick(6);
    global_irq_mask <= 1'b1;
    wait_mode <= 1'b1;
    tick(1);
    chkb("aux_irq", 1'b0, aux_irq);
    chkb("wake_req", 1'b1, wake_req);
    halt_mode <= 1'b1;
    aux_below <= 1'b1;
    wdg_reset <= 1'b1;
    tick(6);
    wdg_reset <= 1'b0;
    chkb("wake_req", 1'b0, wake_req);
    wr(CS, 32'h0);
    rc(cx(1, 0, 1, 0));
    {halt_mode, wait_mode, global_irq_mask} <= 3'h0;
    tick(6);
    ack();
    wr(CS, 32'h10);
    ack();
    wr(CS, 32'h50);
    tick(2);
    chkb("aux_irq", 1'b1, aux_irq);
    ack();
    aux_below <= 1'b0;
    tick(6);
    chkb("aux_irq", 1'b1, aux_irq);
    ack();
    wr(CS, 32'h10);
    aux_below <= 1'b1;
    tick(6);
    ack();
    aux_below <= 1'b0;
    tick(6);
    chkb("aux_irq", 1'b0, aux_irq);
    wr(CS, 32'h50);
    tick(2);
    chkb("aux_irq", 1'b1, aux_irq);
    ack();
    tick(6);
    chkb("aux_irq", 1'b0, aux_irq);
    repeat (8) begin
      aux_below <= 1'($random(seed));
      tick(4);
      rd(CS);
      chkb("flag", aux_below, rdv[5]);
    end
    wdg_reset <= 1'b1;
    tick(1);
    wdg_reset <= 1'b0;
    rc(cx(1, aux_below, 1, 1));
    wr(CS, 32'h0);
    rc(cx(0, aux_below, 0, 0));
    wdg_reset <= 1'b1;
    tick(1);
    wdg_reset <= 1'b0;
    rc(cx(0, aux_below, 0, 1));
    lvd_below <= 1'b1;
    tick(6);
    rc(cx(0, aux_below, 1, 0));
    rd(SIM_MON_STATUS_OFS[3:0]);
    chk("mon", {25'h0, 1'b0, opt_threshold, 1'b1, aux_below, 2'h3}, rdv);
    rd(4'h8);
    chk("resp", {30'h0, SIM_RESP_SLVERR}, {30'h0, rsp});
    rst(1'b0, 1'b1);
    run_wait(4000, 4200);
    rc(cx(0, 0, 0, 0));
    conclude();
  end
endmodule
`default_nettype wire
